// file: rtl/pfci_host.sv
// Host controller driving a byte-wide parallel flash through its pins
`timescale 1ns/1ns
module pfci_host
  import pfci_pkg::*;
#(
  parameter logic [ADDR_W-1:0] UNLOCK_ADDR1 = 18'h00001,
  parameter logic [ADDR_W-1:0] UNLOCK_ADDR2 = 18'h00002,
  parameter logic [7:0] UNLOCK_DATA1 = 8'h01,
  parameter logic [7:0] UNLOCK_DATA2 = 8'h02,
  parameter logic [7:0] PROG_CODE = 8'h03,
  parameter logic [7:0] ERASE_SETUP_CODE = 8'h04,
  parameter logic [7:0] CHIP_ERASE_CODE = 8'h05,
  parameter bit BOOT_TOP = 1'b1,
  parameter int POLL_LIMIT = POLL_LIMIT_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic poll_data_mode,
  input wire logic boot_locked,
  output logic resp_valid,
  output logic [DATA_W-1:0] resp_data,
  output logic resp_err,
  output logic [ADDR_W-1:0] address_in,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic write_en_n,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in
);
  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_WLOW, S_WHIGH, S_RWAIT, S_RGAP, S_DONE} pfci_st_t;

  logic rst_m, rst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  logic [DATA_W-1:0] data_s;
  // Flash data is asynchronous to ref_clk
  pfci_sync #(.W(DATA_W)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(data_in),
    .q(data_s)
  );

  pfci_st_t state;
  pfci_op_t op;
  logic [2:0] step;
  logic [7:0] cnt;
  logic [31:0] poll_cnt;
  logic [DATA_W-1:0] wdata;
  logic [ADDR_W-1:0] addr_r;
  logic first_rd, prev6, fin, err;

  // Command sequence decode for the bus write about to be loaded
  wire op_prog = (op == PFCI_PROG);
  wire [2:0] last_step = op_prog ? 3'(PROG_STEPS - 1) : 3'(ERASE_STEPS - 1);
  wire at_last = (step == last_step);
  wire [2:0] seq_step = (state == S_WHIGH) ? (step + 3'h1) : 3'h0;
  wire seq_last = (seq_step == last_step);
  wire use_u2 = (seq_step == 3'd1) || (seq_step == 3'd4);
  wire [ADDR_W-1:0] seq_addr = !seq_last ? (use_u2 ? UNLOCK_ADDR2 : UNLOCK_ADDR1) :
                               (op == PFCI_CHIP_ERASE) ? UNLOCK_ADDR1 : addr_r;
  wire [7:0] last_data = op_prog ? wdata :
                         (op == PFCI_CHIP_ERASE) ? CHIP_ERASE_CODE : BLOCK_ERASE_CODE;
  wire [7:0] mid_data = op_prog ? PROG_CODE : ERASE_SETUP_CODE;
  wire [7:0] seq_data = seq_last ? last_data : (seq_step == 3'd2) ? mid_data :
                        use_u2 ? UNLOCK_DATA2 : UNLOCK_DATA1;

  // Boot block window depends on variant; locked device would ignore the attempt anyway
  wire [3:0] req_sel = req_addr[BOOT_MSB:BOOT_LSB];
  wire req_boot = BOOT_TOP ? (req_sel == BOOT_TOP_SEL) : (req_sel == BOOT_BOT_SEL);
  wire req_refused = boot_locked && req_boot &&
                     ((req_op == 2'(PFCI_PROG)) || (req_op == 2'(PFCI_BLOCK_ERASE)));

  // Completion test on each poll read
  wire data_poll_ok = op_prog ? (data_s[7] == wdata[7]) : data_s[7];
  wire toggle_ok = !first_rd && (data_s[6] == prev6);
  wire poll_done = poll_data_mode ? data_poll_ok : toggle_ok;
  wire rd_end = (cnt == 8'(RD_CYC - 1));
  wire poll_timeout = (poll_cnt == 32'(POLL_LIMIT));

  // Pin decode from state
  assign req_ready = (state == S_IDLE);
  assign chip_sel_n = !((state == S_WLOW) || (state == S_WHIGH) || (state == S_RWAIT));
  assign write_en_n = (state != S_WLOW);
  assign out_en_n = (state != S_RWAIT);
  // Drive data only while the device output enable is off
  assign data_oe = (state == S_LOAD) || (state == S_WLOW) || (state == S_WHIGH);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= PFCI_READ;
      step <= 3'h0;
      cnt <= 8'h00;
      poll_cnt <= 32'h0;
      wdata <= 8'h00;
      addr_r <= '0;
      first_rd <= 1'b1;
      prev6 <= 1'b0;
      fin <= 1'b0;
      err <= 1'b0;
      address_in <= '0;
      data_out <= 8'h00;
      resp_valid <= 1'b0;
      resp_data <= 8'h00;
      resp_err <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (req_valid) begin
            op <= pfci_op_t'(req_op);
            addr_r <= req_addr;
            wdata <= req_data;
            step <= 3'h0;
            cnt <= 8'h00;
            poll_cnt <= 32'h0;
            first_rd <= 1'b1;
            fin <= 1'b0;
            err <= 1'b0;
            address_in <= req_addr;
            if (req_refused) begin
              err <= 1'b1;
              state <= S_DONE;
            end else if (req_op == 2'(PFCI_READ)) begin
              state <= S_RWAIT;
            end else begin
              // First unlock write is the same for every command
              address_in <= seq_addr;
              data_out <= seq_data;
              state <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          // Pins were loaded on entry, so they settle a cycle before select and strobe fall
          cnt <= 8'h00;
          state <= S_WLOW;
        end
        S_WLOW: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(WP_CYC - 1)) begin
            cnt <= 8'h00;
            state <= S_WHIGH;
          end
        end
        S_WHIGH: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(WPH_CYC - 1)) begin
            cnt <= 8'h00;
            if (at_last) begin
              address_in <= addr_r;
              state <= S_RWAIT;
            end else begin
              address_in <= seq_addr;
              data_out <= seq_data;
              step <= step + 3'h1;
              state <= S_LOAD;
            end
          end
        end
        S_RWAIT: begin
          cnt <= cnt + 8'h01;
          if (rd_end) begin
            cnt <= 8'h00;
            resp_data <= data_s;
            prev6 <= data_s[6];
            first_rd <= 1'b0;
            poll_cnt <= poll_cnt + 32'h1;
            if (op == PFCI_READ || poll_done) begin
              fin <= 1'b1;
            end else if (poll_timeout) begin
              fin <= 1'b1;
              err <= 1'b1;
            end
            state <= S_RGAP;
          end
        end
        S_RGAP: begin
          // Output enable rises between polls so each is a separate read
          state <= fin ? S_DONE : S_RWAIT;
        end
        S_DONE: begin
          resp_valid <= 1'b1;
          resp_err <= err;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Checking helpers: write strobes since the request was taken
  logic [3:0] we_falls;
  logic we_d;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      we_falls <= 4'h0;
      we_d <= 1'b1;
    end else begin
      we_d <= write_en_n;
      if (state == S_IDLE) begin
        we_falls <= 4'h0;
      end else if (we_d && !write_en_n) begin
        we_falls <= we_falls + 4'h1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_write_strobe_form: assert property ($fell(write_en_n) |->
    !chip_sel_n && out_en_n ##1 !write_en_n ##1 write_en_n)
    else $error("write strobe shape or select wrong");
  a_read_strobes: assert property (!out_en_n |-> !chip_sel_n && write_en_n && !data_oe)
    else $error("read without select or with strobe or drive");
  a_write_pins_stable: assert property (!write_en_n || $fell(chip_sel_n) ##0 !write_en_n |=>
    $stable(address_in) && $stable(data_out) && data_oe)
    else $error("address or data moved during write");
  a_prog_seq_len: assert property ((op == PFCI_PROG) && $past(state == S_WHIGH) &&
    (state == S_RWAIT) |-> we_falls == 4'(PROG_STEPS))
    else $error("program sequence length wrong");
  a_erase_seq_len: assert property ((op != PFCI_PROG) && $past(state == S_WHIGH) &&
    (state == S_RWAIT) |-> we_falls == 4'(ERASE_STEPS))
    else $error("erase sequence length wrong");
  a_poll_finish: assert property ((state == S_RWAIT) && rd_end && (op != PFCI_READ) &&
    poll_done |-> ##3 resp_valid && !resp_err)
    else $error("completed poll not reported");
  a_resp_idle_bus: assert property (resp_valid |-> chip_sel_n && !data_oe)
    else $error("response while bus busy");

  c_program: cover property (resp_valid && !resp_err && op == PFCI_PROG);
  c_block_erase: cover property (resp_valid && !resp_err && op == PFCI_BLOCK_ERASE);
  c_read: cover property (resp_valid && op == PFCI_READ);
  c_refused: cover property (resp_valid && resp_err);
endmodule

// file: rtl/pfci_pkg.sv
// Shared constants for the parallel flash command host
package pfci_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int CLK_NS = 50;
  // Bus timing in ns, converted to whole ref_clk cycles (least times round up)
  localparam int T_ACC_NS = 90;
  localparam int T_WP_NS = 70;
  localparam int T_WPH_NS = 50;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;
  localparam int RD_CYC = ACC_CYC + SYNC_CYC;
  localparam int PROG_STEPS = 4;
  localparam int ERASE_STEPS = 6;
  localparam logic [7:0] BLOCK_ERASE_CODE = 8'h30;
  localparam int BOOT_MSB = 17;
  localparam int BOOT_LSB = 14;
  localparam logic [3:0] BOOT_TOP_SEL = 4'hf;
  localparam logic [3:0] BOOT_BOT_SEL = 4'h0;
  localparam int POLL_LIMIT_DEF = 2000000;
  typedef enum logic [1:0] {PFCI_READ, PFCI_PROG, PFCI_CHIP_ERASE, PFCI_BLOCK_ERASE} pfci_op_t;
endpackage

// file: rtl/pfci_sync.sv
// Two-stage synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ns
module pfci_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: verification/pfci_flash_model.sv
// Behavioural flash device facing the host pins
`timescale 1ns/1ns
module pfci_flash_model
  import pfci_pkg::*;
#(
  parameter bit LOCKED = 1'b1,
  parameter int BUSY_READS = 3
) (
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  logic [7:0] mem [int];
  logic [ADDR_W-1:0] a_lat;
  logic [7:0] pdat = 8'h00;
  logic [7:0] cur = 8'h00;
  int step = 0;
  int busy = 0;
  bit is_prog = 0;
  bit tog = 0;
  function automatic int blk(input logic [ADDR_W-1:0] a);
    return a >= 18'h3c000 ? 4 : a >= 18'h3a000 ? 3 : a >= 18'h38000 ? 2 : a >= 18'h20000;
  endfunction
  function automatic logic [7:0] rd(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  task automatic erase(input int b);
    foreach (mem[k]) if (blk(k) == b && !(LOCKED && b == 4)) mem[k] = 8'hff;
  endtask
  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bit lk;
    lk = LOCKED && blk(a) == 4;
    case (step)
      0, 4: step = (a == 18'h1 && d == 8'h01) ? step + 1 : 0;
      1, 5: step = (a == 18'h2 && d == 8'h02) ? step + 1 : 0;
      2: step = (a == 18'h1 && d == 8'h03) ? 3 : (a == 18'h1 && d == 8'h04) ? 4 : 0;
      3: begin
        if (!lk) mem[a] = rd(a) & d;
        pdat = d;
        is_prog = 1;
        busy = BUSY_READS;
        step = 0;
      end
      default: begin
        is_prog = 0;
        busy = BUSY_READS;
        if (a == 18'h1 && d == 8'h05) for (int b = 0; b < 5; b++) erase(b);
        else if (d == BLOCK_ERASE_CODE && !lk) erase(blk(a));
        else busy = 0;
        step = 0;
      end
    endcase
  endtask
  always @(negedge write_en_n or negedge chip_sel_n) a_lat = address_in;
  always @(posedge write_en_n) begin
    if (!chip_sel_n && busy == 0) cmd(a_lat, wdata);
  end
  always @(negedge out_en_n) begin
    cur = rd(address_in);
    if (busy > 0) cur[7:6] = {is_prog ? ~pdat[7] : 1'b0, tog};
  end
  always @(posedge out_en_n) begin
    if (busy > 0) begin
      busy--;
      tog = !tog;
    end
  end
  // Released pins show the inverse so a stale value can never pass
  assign rdata = (!chip_sel_n && !out_en_n && write_en_n) ? cur : ~cur;
endmodule

// file: verification/tb.sv
// Testbench for the parallel flash command host
`timescale 1ns/1ns
module tb;
  import pfci_pkg::*;
  logic ref_clk = 0, resetn = 0, req_valid = 0, req_ready, poll_data_mode = 1, boot_locked = 0;
  logic [1:0] req_op = 0;
  logic [ADDR_W-1:0] req_addr = 0, address_in;
  logic [DATA_W-1:0] req_data = 0, resp_data, data_out, fl_out, bus;
  logic resp_valid, resp_err, chip_sel_n, out_en_n, write_en_n, data_oe;
  int errors = 0, n_checks = 0;
  bit pins_used;
  always #25 ref_clk = ~ref_clk;
  assign bus = data_oe ? data_out : fl_out;
  always @(negedge chip_sel_n) pins_used = 1;
  pfci_host #(.POLL_LIMIT(8)) u_pfci_host (.ref_clk(ref_clk), .resetn(resetn),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .poll_data_mode(poll_data_mode), .boot_locked(boot_locked),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_err(resp_err),
    .address_in(address_in), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .data_out(data_out), .data_oe(data_oe), .data_in(bus));
  pfci_flash_model u_pfci_flash_model (.address_in(address_in), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n), .wdata(bus), .rdata(fl_out));
  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(input logic [1:0] o, input logic [17:0] a, input logic [7:0] d,
    input logic m, input logic [7:0] exp, input logic ex_err);
    int n;
    n = 0;
    @(posedge ref_clk);
    chk("req_ready", req_ready, 1'b1);
    req_op <= o;
    req_addr <= a;
    req_data <= d;
    poll_data_mode <= m;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(posedge ref_clk);
    chk("req_ready", req_ready, 1'b0);
    while (resp_valid !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk("resp_valid", resp_valid, 1'b1);
    if (resp_valid !== 1'b1) end_of_test();
    chk("resp_err", resp_err, ex_err);
    if (!ex_err) chk("resp_data", resp_data, exp);
  endtask
  task automatic t_prog;
    op(2'd0, 18'h00100, 8'h00, 1'b1, 8'hff, 1'b0);
    op(2'd1, 18'h00100, 8'h5a, 1'b1, 8'h5a, 1'b0);
    op(2'd1, 18'h21000, 8'h3c, 1'b0, 8'h3c, 1'b0);
    // A one cannot be programmed back, so bit 7 never matches and the poll times out
    op(2'd1, 18'h00100, 8'hf0, 1'b1, 8'h50, 1'b1);
    op(2'd0, 18'h00100, 8'h00, 1'b1, 8'h50, 1'b0);
  endtask
  task automatic t_block;
    op(2'd3, 18'h00000, 8'h00, 1'b1, 8'hff, 1'b0);
    op(2'd0, 18'h00100, 8'h00, 1'b0, 8'hff, 1'b0);
    op(2'd0, 18'h21000, 8'h00, 1'b0, 8'h3c, 1'b0);
  endtask
  task automatic t_refuse;
    boot_locked <= 1'b1;
    @(posedge ref_clk);
    pins_used = 0;
    op(2'd1, 18'h3c010, 8'h00, 1'b1, 8'h00, 1'b1);
    op(2'd3, 18'h3ffff, 8'h00, 1'b0, 8'h00, 1'b1);
    chk("pins_used", pins_used, 1'b0);
    op(2'd1, 18'h3a000, 8'h81, 1'b1, 8'h81, 1'b0);
  endtask
  task automatic t_chip;
    op(2'd2, 18'h00000, 8'h00, 1'b0, 8'hff, 1'b0);
    op(2'd0, 18'h21000, 8'h00, 1'b1, 8'hff, 1'b0);
    op(2'd0, 18'h3a000, 8'h00, 1'b1, 8'hff, 1'b0);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_prog();
    t_block();
    t_refuse();
    t_chip();
    end_of_test();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
endmodule
